// ==== rgc_consts.vh ====
`ifndef RGC_CONSTS_VH
`define RGC_CONSTS_VH

// ----------------------------------------------------------------
// Register map and bus answers
// ----------------------------------------------------------------
`define RGC_ADDR_W 8
`define RGC_OFF_CTRL 8'h00
`define RGC_OFF_EVENT 8'h04
`define RGC_OFF_RISE_SEL 8'h08
`define RGC_OFF_FALL_SEL 8'h0c
`define RGC_OFF_REF_SEL 8'h10
`define RGC_OFF_CURRENT 8'h14
`define RGC_RESP_OKAY 2'b00
`define RGC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define RGC_CTRL_ENABLE 0
`define RGC_CTRL_GO 1
`define RGC_CTRL_ONE_SHOT 2
`define RGC_CTRL_RISE_EDGE 3
`define RGC_CTRL_FALL_EDGE 4
`define RGC_CTRL_MODE_LO 5
`define RGC_CTRL_MODE_HI 6

// ----------------------------------------------------------------
// Event register fields
// ----------------------------------------------------------------
`define RGC_EVT_RISE_POL 0
`define RGC_EVT_FALL_POL 1
`define RGC_EVT_READY 2
`define RGC_EVT_TIMING 3
`define RGC_EVT_ONE_SHOT_BUSY 4

// ----------------------------------------------------------------
// Field widths, modes and reset values
// ----------------------------------------------------------------
`define RGC_SEL_W 4
`define RGC_REF_W 3
`define RGC_CUR_W 5
`define RGC_MODE_FALLING 2'b00
`define RGC_MODE_RISING 2'b01
`define RGC_MODE_ALTERNATING 2'b10
`define RGC_RST_MODE 2'b00
`define RGC_RST_SEL 4'h0
`define RGC_RST_REF 3'h0
`define RGC_RST_CUR 5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RGC_CLK_PERIOD_NS 5
`define RGC_ONE_SHOT_NS 50
`define RGC_STABILIZE_NS 1000
`define RGC_CNT_W 16

`endif

// ==== rgc_ramp_control.v ====
// Behaviour
// - Rise input chosen by four-bit source select.
// - Fall input chosen by four-bit source select.
// - Each input has its own polarity bit.
// - Rise alone sets output; fall alone clears.
// - Neither active: output holds its value.
// - Both active: fall wins, output false.
// - Level or edge detection per input.
// - Three-bit reference input select field.
// - Current select field sets ramp slope.
// - Two-bit mode: falling, rising, alternating.
// - Discharge, source and sink switch meanings.
// - Falling: source open, sink closed, discharge toggles.
// - Rising: source closed, sink open, discharge toggles.
// - Alternating: discharge open, source/sink alternate.
// - Alternating: source and sink never both closed.
// - One-shot enforces minimum discharge or direction time.
// - One-shot ignores edges, suspends levels.
// - Ready flag after analog stabilisation time.
// - Start always triggers one one-shot period.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rgc_consts.vh"

module rgc_ramp_control #(
	parameter NUM_PERIPH = 15,
	parameter STABILIZE_CYCLES = (`RGC_STABILIZE_NS + `RGC_CLK_PERIOD_NS - 1) / `RGC_CLK_PERIOD_NS
) (
	input wire aclk,
	input wire aresetn,
	input wire [`RGC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`RGC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire rise_timing_pin,
	input wire fall_timing_pin,
	input wire [NUM_PERIPH-1:0] periph_sources,
	output wire ramp_enable,
	output wire [`RGC_REF_W-1:0] reference_input_select,
	output wire [`RGC_CUR_W-1:0] ramp_current_select,
	output wire discharge_switch,
	output wire source_switch,
	output wire sink_switch
);
	localparam integer ONE_SHOT_CYCLES =
		(`RGC_ONE_SHOT_NS + `RGC_CLK_PERIOD_NS - 1) / `RGC_CLK_PERIOD_NS;
	localparam integer STAB_CYCLES = STABILIZE_CYCLES;
	localparam [`RGC_CNT_W-1:0] ONE_SHOT_LOAD = ONE_SHOT_CYCLES[`RGC_CNT_W-1:0];
	localparam [`RGC_CNT_W-1:0] STAB_LOAD = STAB_CYCLES[`RGC_CNT_W-1:0];

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	reg awready_reg, wready_reg, aw_full_reg, w_full_reg, bvalid_reg, wstrb0_reg;
	reg arready_reg, rvalid_reg, rd_hit, wr_hit;
	reg [1:0] bresp_reg, rresp_reg;
	reg [`RGC_ADDR_W-1:0] awaddr_reg;
	reg [31:0] wdata_reg, rdata_reg, rdata_next;
	wire do_write, wr_ctrl, wr_event;

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	reg enable_reg, run_reg, one_shot_enable_reg, rise_detect_mode_reg, fall_detect_mode_reg;
	reg rise_polarity_reg, fall_polarity_reg, ready_reg, timing_reg, timing_next;
	reg discharge_reg, source_reg, sink_reg, discharge_next, source_next, sink_next;
	reg [1:0] mode_reg;
	reg [`RGC_SEL_W-1:0] rise_source_select_reg, fall_source_select_reg;
	reg [`RGC_REF_W-1:0] reference_input_select_reg;
	reg [`RGC_CUR_W-1:0] ramp_current_select_reg;
	reg [`RGC_CNT_W-1:0] stab_cnt_reg, os_cnt_reg;
	wire go_start, os_busy, rise_active, fall_active;
	wire [1:0] ch_active, ch_pin, ch_pol, ch_mode;
	wire [2*`RGC_SEL_W-1:0] ch_select;

	// ----------------------------------------------------------------
	// Write channel: address and data taken in either order
	// ----------------------------------------------------------------
	assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_ctrl = do_write & wstrb0_reg & (awaddr_reg == `RGC_OFF_CTRL);
	assign wr_event = do_write & wstrb0_reg & (awaddr_reg == `RGC_OFF_EVENT);

	always @* begin
		case (awaddr_reg)
		`RGC_OFF_CTRL, `RGC_OFF_EVENT, `RGC_OFF_RISE_SEL, `RGC_OFF_FALL_SEL,
		`RGC_OFF_REF_SEL, `RGC_OFF_CURRENT: wr_hit = 1'b1;
		default: wr_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RGC_RESP_OKAY;
			awaddr_reg <= {`RGC_ADDR_W{1'b0}};
			wdata_reg <= 32'h00000000;
			wstrb0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end else if (!aw_full_reg && !bvalid_reg) begin
				awready_reg <= 1'b1;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
				wready_reg <= 1'b0;
			end else if (!w_full_reg && !bvalid_reg) begin
				wready_reg <= 1'b1;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always @* begin
		rd_hit = 1'b1;
		rdata_next = 32'h00000000;
		case (s_axi_araddr)
		`RGC_OFF_CTRL: begin
			rdata_next[`RGC_CTRL_ENABLE] = enable_reg;
			rdata_next[`RGC_CTRL_GO] = run_reg;
			rdata_next[`RGC_CTRL_ONE_SHOT] = one_shot_enable_reg;
			rdata_next[`RGC_CTRL_RISE_EDGE] = rise_detect_mode_reg;
			rdata_next[`RGC_CTRL_FALL_EDGE] = fall_detect_mode_reg;
			rdata_next[`RGC_CTRL_MODE_HI:`RGC_CTRL_MODE_LO] = mode_reg;
		end
		`RGC_OFF_EVENT: begin
			rdata_next[`RGC_EVT_RISE_POL] = rise_polarity_reg;
			rdata_next[`RGC_EVT_FALL_POL] = fall_polarity_reg;
			rdata_next[`RGC_EVT_READY] = ready_reg;
			rdata_next[`RGC_EVT_TIMING] = timing_reg;
			rdata_next[`RGC_EVT_ONE_SHOT_BUSY] = os_busy;
		end
		`RGC_OFF_RISE_SEL: rdata_next[`RGC_SEL_W-1:0] = rise_source_select_reg;
		`RGC_OFF_FALL_SEL: rdata_next[`RGC_SEL_W-1:0] = fall_source_select_reg;
		`RGC_OFF_REF_SEL: rdata_next[`RGC_REF_W-1:0] = reference_input_select_reg;
		`RGC_OFF_CURRENT: rdata_next[`RGC_CUR_W-1:0] = ramp_current_select_reg;
		default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= `RGC_RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rdata_next;
			rresp_reg <= rd_hit ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	assign go_start = wr_ctrl & wdata_reg[`RGC_CTRL_GO] & enable_reg & ~run_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= 1'b0;
			run_reg <= 1'b0;
			one_shot_enable_reg <= 1'b0;
			rise_detect_mode_reg <= 1'b0;
			fall_detect_mode_reg <= 1'b0;
			mode_reg <= `RGC_RST_MODE;
			rise_polarity_reg <= 1'b0;
			fall_polarity_reg <= 1'b0;
			rise_source_select_reg <= `RGC_RST_SEL;
			fall_source_select_reg <= `RGC_RST_SEL;
			reference_input_select_reg <= `RGC_RST_REF;
			ramp_current_select_reg <= `RGC_RST_CUR;
		end else if (do_write && wstrb0_reg) begin
			if (wr_ctrl) begin
				enable_reg <= wdata_reg[`RGC_CTRL_ENABLE];
				run_reg <= wdata_reg[`RGC_CTRL_GO] & enable_reg & wdata_reg[`RGC_CTRL_ENABLE];
				one_shot_enable_reg <= wdata_reg[`RGC_CTRL_ONE_SHOT];
				rise_detect_mode_reg <= wdata_reg[`RGC_CTRL_RISE_EDGE];
				fall_detect_mode_reg <= wdata_reg[`RGC_CTRL_FALL_EDGE];
				mode_reg <= wdata_reg[`RGC_CTRL_MODE_HI:`RGC_CTRL_MODE_LO];
			end
			if (wr_event) begin
				rise_polarity_reg <= wdata_reg[`RGC_EVT_RISE_POL];
				fall_polarity_reg <= wdata_reg[`RGC_EVT_FALL_POL];
			end
			if (awaddr_reg == `RGC_OFF_RISE_SEL) begin
				rise_source_select_reg <= wdata_reg[`RGC_SEL_W-1:0];
			end
			if (awaddr_reg == `RGC_OFF_FALL_SEL) begin
				fall_source_select_reg <= wdata_reg[`RGC_SEL_W-1:0];
			end
			if (awaddr_reg == `RGC_OFF_REF_SEL) begin
				reference_input_select_reg <= wdata_reg[`RGC_REF_W-1:0];
			end
			if (awaddr_reg == `RGC_OFF_CURRENT) begin
				ramp_current_select_reg <= wdata_reg[`RGC_CUR_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Ready flag after the analog settling time
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			stab_cnt_reg <= {`RGC_CNT_W{1'b0}};
			ready_reg <= 1'b0;
		end else if (!enable_reg) begin
			stab_cnt_reg <= STAB_LOAD;
			ready_reg <= 1'b0;
		end else if (stab_cnt_reg != {`RGC_CNT_W{1'b0}}) begin
			stab_cnt_reg <= stab_cnt_reg - 1'b1;
		end else begin
			ready_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Timing inputs
	// ----------------------------------------------------------------
	assign ch_select = {fall_source_select_reg, rise_source_select_reg};
	assign ch_pin = {fall_timing_pin, rise_timing_pin};
	assign ch_pol = {fall_polarity_reg, rise_polarity_reg};
	assign ch_mode = {fall_detect_mode_reg, rise_detect_mode_reg};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_input
			rgc_timing_input #(.NUM_PERIPH(NUM_PERIPH)) u_input (
				.aclk(aclk), .aresetn(aresetn), .timing_pin(ch_pin[ch]),
				.periph_sources(periph_sources),
				.source_select(ch_select[ch*`RGC_SEL_W +: `RGC_SEL_W]),
				.polarity(ch_pol[ch]), .detect_mode(ch_mode[ch]), .active(ch_active[ch])
			);
		end
	endgenerate

	assign rise_active = ch_active[0];
	assign fall_active = ch_active[1];

	// ----------------------------------------------------------------
	// Timing latch and one-shot timer
	// ----------------------------------------------------------------
	assign os_busy = os_cnt_reg != {`RGC_CNT_W{1'b0}};

	// The latch is frozen while the one-shot runs, so edges seen then are
	// lost and levels take effect once it ends.
	always @* begin
		timing_next = timing_reg;
		if (!run_reg) begin
			timing_next = 1'b0;
		end else if (!os_busy) begin
			if (fall_active) begin
				timing_next = 1'b0;
			end else if (rise_active) begin
				timing_next = 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			timing_reg <= 1'b0;
			os_cnt_reg <= {`RGC_CNT_W{1'b0}};
		end else begin
			timing_reg <= timing_next;
			if (go_start) begin
				os_cnt_reg <= ONE_SHOT_LOAD;
			end else if (!run_reg) begin
				os_cnt_reg <= {`RGC_CNT_W{1'b0}};
			end else if (one_shot_enable_reg && (timing_next != timing_reg)) begin
				os_cnt_reg <= ONE_SHOT_LOAD;
			end else if (os_busy) begin
				os_cnt_reg <= os_cnt_reg - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Analog switch control
	// ----------------------------------------------------------------
	always @* begin
		discharge_next = 1'b1;
		source_next = 1'b0;
		sink_next = 1'b0;
		// The latch stays false through the start one-shot, so the capacitor is
		// held shorted in the ramp modes while source or sink stays as the mode says.
		if (run_reg) begin
			case (mode_reg)
			`RGC_MODE_RISING: begin
				discharge_next = ~timing_reg;
				source_next = 1'b1;
			end
			`RGC_MODE_ALTERNATING: begin
				discharge_next = 1'b0;
				source_next = timing_reg;
				sink_next = ~timing_reg;
			end
			default: begin
				discharge_next = ~timing_reg;
				sink_next = 1'b1;
			end
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			discharge_reg <= 1'b1;
			source_reg <= 1'b0;
			sink_reg <= 1'b0;
		end else begin
			discharge_reg <= discharge_next;
			source_reg <= source_next;
			sink_reg <= sink_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign ramp_enable = enable_reg;
	assign reference_input_select = reference_input_select_reg;
	assign ramp_current_select = ramp_current_select_reg;
	assign discharge_switch = discharge_reg;
	assign source_switch = source_reg;
	assign sink_switch = sink_reg;
endmodule

// ==== rgc_ramp_control_asserts.sv ====
`timescale 1ns/100ps
`include "rgc_consts.vh"

// ----------------------------------------------------------------
// Port checker for the ramp generator control block
// ----------------------------------------------------------------
module rgc_ramp_control_asserts #(
	parameter NUM_PERIPH = 15,
	parameter STABILIZE_CYCLES = 200
) (
	input wire aclk,
	input wire aresetn,
	input wire [`RGC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`RGC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire rise_timing_pin,
	input wire fall_timing_pin,
	input wire [NUM_PERIPH-1:0] periph_sources,
	input wire ramp_enable,
	input wire [`RGC_REF_W-1:0] reference_input_select,
	input wire [`RGC_CUR_W-1:0] ramp_current_select,
	input wire discharge_switch,
	input wire source_switch,
	input wire sink_switch
);
	wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_take = s_axi_arvalid && s_axi_arready;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sw_excl_a: assert property (!(source_switch && sink_switch))
		else $error("source and sink switches closed together");
	idle_discharge_a: assert property (!ramp_enable [*3] |->
		discharge_switch && !source_switch && !sink_switch)
		else $error("switches not idle while disabled");
	wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	unmapped_rd_a: assert property (rd_take && s_axi_araddr > `RGC_OFF_CURRENT |=>
		s_axi_rresp == `RGC_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	ref_write_a: assert property (
		wr_both && s_axi_wstrb[0] && s_axi_awaddr == `RGC_OFF_REF_SEL |-> ##2
		{29'h0, reference_input_select} == ($past(s_axi_wdata, 2) & 32'h7))
		else $error("reference select not updated");
	cur_write_a: assert property (
		wr_both && s_axi_wstrb[0] && s_axi_awaddr == `RGC_OFF_CURRENT |-> ##2
		{27'h0, ramp_current_select} == ($past(s_axi_wdata, 2) & 32'h1f))
		else $error("current select not updated");
endmodule

bind rgc_ramp_control rgc_ramp_control_asserts #(.NUM_PERIPH(NUM_PERIPH),
	.STABILIZE_CYCLES(STABILIZE_CYCLES)) rgc_ramp_control_asserts_inst (.*);

// ==== rgc_source_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Timing sources on the far side: two pins and peripheral outputs
// ----------------------------------------------------------------
module rgc_source_model #(
	parameter NUM_PERIPH = 15
) (
	input wire aclk,
	input wire source_switch,
	input wire sink_switch,
	output logic rise_timing_pin,
	output logic fall_timing_pin,
	output logic [NUM_PERIPH-1:0] periph_sources
);
	localparam int TRIP_LEVEL = 6;
	logic [NUM_PERIPH-1:0] periph_drv;
	logic closed_loop;
	int ramp_level;

	// Every source is settled from time zero, before any selection picks it.
	initial begin
		rise_timing_pin = 1'b0;
		fall_timing_pin = 1'b0;
		periph_drv = '0;
		closed_loop = 1'b0;
	end

	// In closed loop the top peripheral source is a comparator on a crude
	// capacitor level that climbs while sourcing and drops while sinking.
	assign periph_sources = closed_loop ?
		{ramp_level >= TRIP_LEVEL, periph_drv[NUM_PERIPH-2:0]} : periph_drv;

	always @(posedge aclk) begin
		if (!closed_loop) begin
			ramp_level <= 0;
		end else if (source_switch) begin
			ramp_level <= ramp_level + 1;
		end else if (sink_switch) begin
			ramp_level <= ramp_level - 1;
		end
	end

	task automatic close_loop(input logic on);
		@(posedge aclk);
		closed_loop <= on;
	endtask

	// Sources change just after a clock edge, after an optional lag in cycles.
	task automatic drive(input logic r, input logic f, input logic [NUM_PERIPH-1:0] p,
		input int lag);
		repeat (lag + 1) @(posedge aclk);
		rise_timing_pin <= r;
		fall_timing_pin <= f;
		periph_drv <= p;
	endtask
endmodule

// ==== rgc_timing_input.v ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// One timing input: source selection, synchroniser, polarity and
// level or edge detection.
// ----------------------------------------------------------------
module rgc_timing_input #(
	parameter NUM_PERIPH = 15
) (
	input wire aclk,
	input wire aresetn,
	input wire timing_pin,
	input wire [NUM_PERIPH-1:0] periph_sources,
	input wire [3:0] source_select,
	input wire polarity,
	input wire detect_mode,
	output wire active
);
	wire [NUM_PERIPH:0] all_sources;
	reg [NUM_PERIPH:0] sync1_reg;
	reg [NUM_PERIPH:0] sync2_reg;
	reg raw_sel;
	reg level_d_reg;
	wire level;

	assign all_sources = {periph_sources, timing_pin};

	// Code zero picks the pin, higher codes the peripheral outputs.
	always @* begin
		raw_sel = 1'b0;
		if (source_select <= NUM_PERIPH) begin
			raw_sel = sync2_reg[source_select];
		end
	end

	// Every source is asynchronous, so each passes two flops before the select looks.
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= {(NUM_PERIPH+1){1'b0}};
			sync2_reg <= {(NUM_PERIPH+1){1'b0}};
			level_d_reg <= 1'b0;
		end else begin
			sync1_reg <= all_sources;
			sync2_reg <= sync1_reg;
			level_d_reg <= level;
		end
	end

	assign level = raw_sel ^ polarity;
	assign active = detect_mode ? (level & ~level_d_reg) : level;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "rgc_consts.vh"

// ----------------------------------------------------------------
// Register bus tasks and switch sequences
// ----------------------------------------------------------------
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire rise_timing_pin, fall_timing_pin, ramp_enable;
	wire discharge_switch, source_switch, sink_switch;
	wire [14:0] periph_sources;
	wire [2:0] reference_input_select;
	wire [4:0] ramp_current_select;
	int failures = 0, num_checks = 0;
	logic [31:0] rd;
	logic [1:0] resp, m;
	int lvl;
	logic [31:0] msk [4] = '{32'hf, 32'hf, 32'h7, 32'h1f};

	always #2.5 aclk = ~aclk;

	rgc_ramp_control #(.STABILIZE_CYCLES(4)) rgc_ramp_control_inst (.*);
	rgc_source_model rgc_source_model_inst (.*);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize;
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic pins(input logic r, input logic f, input logic [14:0] p);
		rgc_source_model_inst.drive(r, f, p, 0);
	endtask

	// Expected switches {discharge, source, sink} for a mode and a timing state.
	task automatic check_sw(input logic [1:0] md, input logic t);
		logic [2:0] e;
		e = (md == 2'b10) ? {1'b0, t, !t} : (md == 2'b01) ? {!t, 2'b10} : {!t, 2'b01};
		check("switches", {discharge_switch, source_switch, sink_switch}, e);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			axi_read(8'(i * 4), rd, resp);
			check("reset value", rd, 32'h0);
			check("read response", resp, `RGC_RESP_OKAY);
		end
		axi_read(8'h40, rd, resp);
		check("unmapped read data", rd, 32'h0);
		check("unmapped read response", resp, `RGC_RESP_SLVERR);
		axi_write(8'h40, 32'hffffffff, 4'hf, resp);
		check("unmapped write response", resp, `RGC_RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			axi_write(8'(8 + i * 4), 32'hffffffff, 4'hf, resp);
			axi_write(8'(8 + i * 4), 32'h0, 4'h0, resp);
			axi_read(8'(8 + i * 4), rd, resp);
			check("field width", rd, msk[i]);
		end
		check("reference select", reference_input_select, 32'h7);
		check("current select", ramp_current_select, 32'h1f);
		for (int i = 0; i < 4; i++) axi_write(8'(8 + i * 4), 32'h0, 4'h1, resp);
		axi_write(`RGC_OFF_CTRL, 32'h1, 4'h1, resp);
		rd = 32'h0;
		repeat (40) if (rd[`RGC_EVT_READY] !== 1'b1) axi_read(`RGC_OFF_EVENT, rd, resp);
		check("ready flag", rd[`RGC_EVT_READY], 1'b1);
		check("ramp enable", ramp_enable, 1'b1);
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			axi_write(`RGC_OFF_CTRL, {25'h0, m, 5'h01}, 4'h1, resp);
			pins(1'b1, 1'b0, 15'h0);
			axi_write(`RGC_OFF_CTRL, {25'h0, m, 5'h03}, 4'h1, resp);
			cycles(2);
			check_sw(m, 1'b0);
			cycles(20);
			check_sw(m, 1'b1);
			pins(1'b0, 1'b0, 15'h0);
			cycles(8);
			check_sw(m, 1'b1);
			pins(1'b0, 1'b1, 15'h0);
			cycles(8);
			check_sw(m, 1'b0);
			pins(1'b1, 1'b1, 15'h0);
			cycles(8);
			check_sw(m, 1'b0);
			pins(1'b1, 1'b0, 15'h0);
			cycles(8);
			check_sw(m, 1'b1);
		end
		axi_write(`RGC_OFF_CTRL, 32'h21, 4'h1, resp);
		rgc_source_model_inst.drive(1'b0, 1'b0, 15'h0, 3);
		// Same peripheral on both inputs, with the falling side inverted.
		axi_write(`RGC_OFF_RISE_SEL, 32'h5, 4'h1, resp);
		axi_write(`RGC_OFF_FALL_SEL, 32'h5, 4'h1, resp);
		axi_write(`RGC_OFF_EVENT, 32'h2, 4'h1, resp);
		axi_write(`RGC_OFF_CTRL, 32'h23, 4'h1, resp);
		cycles(20);
		check_sw(2'b01, 1'b0);
		pins(1'b0, 1'b0, 15'h0010);
		cycles(8);
		check_sw(2'b01, 1'b1);
		pins(1'b0, 1'b0, 15'h0);
		cycles(8);
		check_sw(2'b01, 1'b0);
		axi_write(`RGC_OFF_CTRL, 32'h21, 4'h1, resp);
		axi_write(`RGC_OFF_RISE_SEL, 32'h0, 4'h1, resp);
		axi_write(`RGC_OFF_FALL_SEL, 32'h0, 4'h1, resp);
		axi_write(`RGC_OFF_EVENT, 32'h0, 4'h1, resp);
		// Edge detection on both inputs with the one-shot enabled.
		axi_write(`RGC_OFF_CTRL, 32'h3f, 4'h1, resp);
		cycles(20);
		check_sw(2'b01, 1'b0);
		pins(1'b1, 1'b0, 15'h0);
		cycles(20);
		check_sw(2'b01, 1'b1);
		pins(1'b1, 1'b1, 15'h0);
		pins(1'b1, 1'b0, 15'h0);
		pins(1'b0, 1'b0, 15'h0);
		pins(1'b1, 1'b0, 15'h0);
		cycles(20);
		check_sw(2'b01, 1'b0);
		pins(1'b0, 1'b0, 15'h0);
		pins(1'b1, 1'b0, 15'h0);
		cycles(20);
		check_sw(2'b01, 1'b1);
		// Closed loop in alternating mode: one comparator drives both inputs.
		axi_write(`RGC_OFF_CTRL, 32'h41, 4'h1, resp);
		axi_write(`RGC_OFF_RISE_SEL, 32'hf, 4'h1, resp);
		axi_write(`RGC_OFF_FALL_SEL, 32'hf, 4'h1, resp);
		axi_write(`RGC_OFF_EVENT, 32'h1, 4'h1, resp);
		rgc_source_model_inst.close_loop(1'b1);
		axi_write(`RGC_OFF_CTRL, 32'h43, 4'h1, resp);
		cycles(60);
		for (int i = 0; i < 8; i++) begin
			cycles(5);
			lvl = rgc_source_model_inst.ramp_level;
			check("ramp level bounded", 32'(lvl >= 0 && lvl <= 12), 32'h1);
		end
		axi_write(`RGC_OFF_CTRL, 32'h0, 4'h1, resp);
		axi_read(`RGC_OFF_EVENT, rd, resp);
		check("ready cleared", rd[`RGC_EVT_READY], 1'b0);
		check("ramp disabled", ramp_enable, 1'b0);
		cycles(4);
		check("idle switches", {discharge_switch, source_switch, sink_switch}, 32'h4);
		summarize();
	end
endmodule
